// *** common/psrb_pkg.sv ***
/*
 psrb_pkg: constants, register offsets, types and timing tables of the pressure sensor
 register bank. Assumes a 50 MHz system clock and a host acting as two-wire bus master.
*/
// Overview of operation
// - mode register up to temperature low byte reachable only with power and release set
// - while gated, writes there are dropped and reads return a fixed filler byte
// - power gate bit at 12h: 0 powered down, 1 active; resets to zero
// - release bit at 13h holds measurement block in reset while zero
// - single-sample measurement ends within 6 ms; more averaging takes longer
// - averaging field 7:5 picks 1 to 64 samples; code 111 forbidden
// - mode 01 measures once then back to standby; mode 10 repeats until standby
// - status bit 0 reads one when results are available and zero while measuring, except on continuous repeats with averaging code 100 or above
package psrb_pkg;

	localparam int        CLK_HZ       = 50_000_000;
	localparam int        MS_CYCLES    = CLK_HZ / 1000;

	localparam logic [7:0] ADDR_IDENT1 = 8'h0f;
	localparam logic [7:0] ADDR_IDENT2 = 8'h10;
	localparam logic [7:0] ADDR_PWR    = 8'h12;
	localparam logic [7:0] ADDR_RST    = 8'h13;
	localparam logic [7:0] ADDR_MODE   = 8'h14;
	localparam logic [7:0] ADDR_STAT   = 8'h19;
	localparam logic [7:0] ADDR_P_HI   = 8'h1a;
	localparam logic [7:0] ADDR_P_LO   = 8'h1b;
	localparam logic [7:0] ADDR_P_FR   = 8'h1c;
	localparam logic [7:0] ADDR_T_HI   = 8'h1d;
	localparam logic [7:0] ADDR_T_LO   = 8'h1e;
	localparam logic [7:0] GATED_LO    = ADDR_MODE;
	localparam logic [7:0] GATED_HI    = ADDR_T_LO;

	localparam logic [7:0] MODE_RESET  = 8'h08;
	localparam logic [7:0] GATED_READ  = 8'h00;
	localparam logic [2:0] AVG_MAX     = 3'h6;
	localparam logic [2:0] AVG_BAD     = 3'h7;

	typedef enum logic [1:0] {
		MM_STANDBY = 2'h0,
		MM_ONESHOT = 2'h1,
		MM_CONT    = 2'h2,
		MM_BAD     = 2'h3
	} psrb_mmode_t;

	// mode register byte: averaging_count, ready_pin_enable, two reserved, mode
	typedef struct packed {
		logic [2:0]  avg;
		logic        rdy_pin_en;
		logic        rsv3;
		logic        rsv2;
		psrb_mmode_t mode;
	} psrb_modecfg_t;

	typedef enum logic [6:0] {
		I2C_IDLE = 7'h01,
		I2C_ADDR = 7'h02,
		I2C_ACKA = 7'h04,
		I2C_WR   = 7'h08,
		I2C_ACKW = 7'h10,
		I2C_RD   = 7'h20,
		I2C_ACKR = 7'h40
	} psrb_i2c_state_t;

	// longest measurement time, milliseconds per averaging code
	function automatic int tm_ms(input logic [2:0] avg);
		case (avg)
			3'h0:    return 6;
			3'h1:    return 9;
			3'h2:    return 16;
			3'h3:    return 30;
			3'h4:    return 60;
			3'h5:    return 120;
			default: return 240;
		endcase
	endfunction : tm_ms

	// continuous repeat period, milliseconds per averaging code
	function automatic int ti_ms(input logic [2:0] avg);
		case (avg)
			3'h5:    return 120;
			3'h6:    return 240;
			3'h7:    return 240;
			default: return 60;
		endcase
	endfunction : ti_ms

endpackage : psrb_pkg

// *** common/psrb_meas_if.sv ***
/*
 psrb_meas_if: control and result signals between the register bank and the measurement
 sequencer. Assumes both ends share clock_in.
*/
interface psrb_meas_if;
	import psrb_pkg::*;
	logic        run_en;
	psrb_mmode_t mode;
	logic [2:0]  avg;
	logic        ready;
	logic        done;
	logic [21:0] press;
	logic [15:0] temp;
	modport ctrl (output run_en, mode, avg, input ready, done, press, temp);
	modport eng  (input run_en, mode, avg, output ready, done, press, temp);
endinterface : psrb_meas_if

// *** src/psrb_meas.sv ***
/*
 psrb_meas: measurement sequencer; times one-shot and continuous measurements and
 latches the sensor words at the end of each. Assumes sensor words are stable inputs.
*/
module psrb_meas #(
	parameter int MS_CYCLES = psrb_pkg::MS_CYCLES
) (
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        sys_rst_in,
	// sensor words
	input  wire logic [21:0] sensor_press_in,
	input  wire logic [15:0] sensor_temp_in,
	// control side
	psrb_meas_if.eng         meas
);
	import psrb_pkg::*;

	typedef struct packed {
		psrb_mmode_t prev;
		logic        busy;
		logic [31:0] cnt;
		logic        ready;
		logic        done;
		logic [21:0] press;
		logic [15:0] temp;
	} psrb_meas_st_t;

	psrb_meas_st_t s_q;
	psrb_meas_st_t s_d;
	logic [2:0]    avg_eff;
	logic [31:0]   tm_cyc;
	logic [31:0]   ti_cyc;
	logic          start;

	always_comb
	begin
		s_d     = s_q;
		s_d.done = 1'b0;
		// forbidden code runs as the longest legal one rather than hanging
		avg_eff = (meas.avg == AVG_BAD) ? AVG_MAX : meas.avg;
		tm_cyc  = 32'(tm_ms(avg_eff) * MS_CYCLES);
		ti_cyc  = 32'(ti_ms(avg_eff) * MS_CYCLES);
		start   = (meas.mode != s_q.prev) && (meas.mode == MM_ONESHOT || meas.mode == MM_CONT);
		s_d.prev = meas.mode;
		if (meas.mode == MM_STANDBY)
		begin
			// abort drops the measurement without touching results
			s_d.busy = 1'b0;
			s_d.cnt  = 32'h0;
		end
		else if (start)
		begin
			s_d.busy  = 1'b1;
			s_d.cnt   = 32'h0;
			s_d.ready = 1'b0;
		end
		else if (s_q.busy)
		begin
			s_d.cnt = s_q.cnt + 32'h1;
			if (meas.mode == MM_CONT && s_q.cnt == ti_cyc - 32'h1)
			begin
				s_d.cnt   = 32'h0;
				s_d.ready = 1'b0;
			end
			if (s_q.cnt == tm_cyc - 32'h1)
			begin
				// set wins over the restart clear when both land together
				s_d.press = sensor_press_in;
				s_d.temp  = sensor_temp_in;
				s_d.ready = 1'b1;
				if (meas.mode == MM_ONESHOT)
				begin
					s_d.busy = 1'b0;
					s_d.done = 1'b1;
				end
			end
		end
		if (sys_rst_in || !meas.run_en)
			s_d = '0;
	end

	always_ff @(posedge clock_in)
		s_q <= s_d;

	assign meas.ready = s_q.ready;
	assign meas.done  = s_q.done;
	assign meas.press = s_q.press;
	assign meas.temp  = s_q.temp;

	chk_avg_limit: assert property (
		@(posedge clock_in) disable iff (sys_rst_in) avg_eff != AVG_BAD)
		else $error("forbidden averaging code reached the timer");
	chk_oneshot_bound: assert property (
		@(posedge clock_in) disable iff (sys_rst_in)
		(s_q.busy && meas.mode == MM_ONESHOT) |-> s_q.cnt < tm_cyc)
		else $error("one-shot measurement overran its time");
	chk_ready_set: assert property (
		@(posedge clock_in) disable iff (sys_rst_in)
		(s_q.busy && !start && meas.run_en && meas.mode != MM_STANDBY
		 && s_q.cnt == tm_cyc - 32'h1) |=> s_q.ready && s_q.press == $past(sensor_press_in))
		else $error("results not latched at measurement end");
	chk_ready_drop: assert property (
		@(posedge clock_in) disable iff (sys_rst_in)
		(start && meas.run_en) |=> !s_q.ready ##1 s_q.busy)
		else $error("ready not cleared at measurement start");
	chk_cont_repeat: assert property (
		@(posedge clock_in) disable iff (sys_rst_in)
		(s_q.busy && meas.run_en && meas.mode == MM_CONT && s_q.prev == MM_CONT
		 && s_q.cnt == ti_cyc - 32'h1) |=> s_q.busy && s_q.cnt == 32'h0)
		else $error("continuous mode did not restart");

endmodule : psrb_meas

// *** src/psrb_top.sv ***
/*
 psrb_top: two-wire target interface and register bank of the pressure sensor, with the
 measurement sequencer inside. Assumes scl and sda are already synchronous to clock_in.
*/
module psrb_top #(
	parameter int         MS_CYCLES    = psrb_pkg::MS_CYCLES,
	parameter logic [6:0] DEV_ADDR     = 7'h5d, // arbitrary
	parameter logic [7:0] IDENT_FIRST  = 8'ha5, // arbitrary
	parameter logic [7:0] IDENT_SECOND = 8'h5a  // arbitrary
) (
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        sys_rst_in,
	// serial bus
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_out,
	// sensor words
	input  wire logic [21:0] sensor_press_in,
	input  wire logic [15:0] sensor_temp_in
);
	import psrb_pkg::*;

	typedef struct packed {
		psrb_i2c_state_t st;
		logic            scl;
		logic            sda;
		logic [3:0]      bits;
		logic [7:0]      sh;
		logic            rw;
		logic            first;
		logic            nack;
		logic [7:0]      ptr;
		logic            oe;
		logic            lvl;
		logic            pwr;
		logic            blk_run;
		psrb_modecfg_t   cfg;
	} psrb_bank_t;

	psrb_bank_t  s_q;
	psrb_bank_t  s_d;
	psrb_meas_if meas ();
	logic        scl_rise;
	logic        scl_fall;
	logic        bus_start;
	logic        bus_stop;
	logic        gate_ok;
	logic        wr_strobe;
	logic        rd_load;
	logic [7:0]  rd_val;
	logic [7:0]  frac_chk;
	logic [7:0]  stat_chk;

	psrb_meas #(
		.MS_CYCLES (MS_CYCLES)
	) u_meas (
		.clock_in        (clock_in),
		.sys_rst_in      (sys_rst_in),
		.sensor_press_in (sensor_press_in),
		.sensor_temp_in  (sensor_temp_in),
		.meas            (meas.eng)
	);

	// read mux; the gated window answers with a fixed filler byte
	function automatic logic [7:0] rd_byte(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			ADDR_IDENT1: v = IDENT_FIRST;
			ADDR_IDENT2: v = IDENT_SECOND;
			ADDR_PWR:    v = {7'h00, s_q.pwr};
			ADDR_RST:    v = {7'h00, s_q.blk_run};
			ADDR_MODE:   v = s_q.cfg;
			ADDR_STAT:   v = {7'h00, meas.ready};
			ADDR_P_HI:   v = meas.press[21:14];
			ADDR_P_LO:   v = meas.press[13:6];
			ADDR_P_FR:   v = {meas.press[5:0], 2'h0};
			ADDR_T_HI:   v = meas.temp[15:8];
			ADDR_T_LO:   v = meas.temp[7:0];
			default:     v = 8'h00;
		endcase
		if (a >= GATED_LO && a <= GATED_HI && !(s_q.pwr && s_q.blk_run))
			v = GATED_READ;
		return v;
	endfunction : rd_byte

	always_comb
	begin
		s_d       = s_q;
		s_d.scl   = scl_in;
		s_d.sda   = sda_in;
		s_d.lvl   = 1'b0;
		scl_rise  = scl_in && !s_q.scl;
		scl_fall  = !scl_in && s_q.scl;
		bus_start = scl_in && s_q.scl && s_q.sda && !sda_in;
		bus_stop  = scl_in && s_q.scl && !s_q.sda && sda_in;
		gate_ok   = s_q.pwr && s_q.blk_run;
		wr_strobe = 1'b0;
		rd_load   = 1'b0;
		rd_val    = rd_byte(s_q.ptr);
		frac_chk  = rd_byte(ADDR_P_FR);
		stat_chk  = rd_byte(ADDR_STAT);
		if (meas.done && s_q.cfg.mode == MM_ONESHOT)
			s_d.cfg.mode = MM_STANDBY;
		case (s_q.st)
			I2C_IDLE: s_d.oe = 1'b0;
			I2C_ADDR, I2C_WR:
			begin
				if (scl_rise)
				begin
					s_d.sh   = {s_q.sh[6:0], sda_in};
					s_d.bits = s_q.bits + 4'h1;
				end
				else if (scl_fall && s_q.bits == 4'h8)
				begin
					s_d.oe = 1'b1;
					if (s_q.st == I2C_ADDR)
					begin
						s_d.rw    = s_q.sh[0];
						s_d.first = 1'b1;
						s_d.st    = I2C_ACKA;
						if (s_q.sh[7:1] != DEV_ADDR)
						begin
							s_d.oe = 1'b0;
							s_d.st = I2C_IDLE;
						end
					end
					else
					begin
						s_d.st = I2C_ACKW;
						if (s_q.first || s_q.rw)
						begin
							s_d.ptr   = s_q.sh;
							s_d.first = 1'b0;
						end
						else
						begin
							wr_strobe = 1'b1;
							s_d.ptr   = s_q.ptr + 8'h01;
							case (s_q.ptr)
								ADDR_PWR:  s_d.pwr = s_q.sh[0];
								ADDR_RST:  s_d.blk_run = s_q.sh[0];
								ADDR_MODE:
									if (gate_ok)
										s_d.cfg = s_q.sh;
								default:   s_d.ptr = s_q.ptr + 8'h01;
							endcase
						end
					end
				end
			end
			I2C_ACKA, I2C_ACKW:
			begin
				if (scl_fall)
				begin
					s_d.bits = 4'h0;
					s_d.oe   = 1'b0;
					s_d.st   = I2C_WR;
					if (s_q.st == I2C_ACKA && s_q.rw)
					begin
						rd_load = 1'b1;
						s_d.sh  = rd_val;
						s_d.oe  = !rd_val[7];
						s_d.ptr = s_q.ptr + 8'h01;
						s_d.st  = I2C_RD;
					end
				end
			end
			I2C_RD:
			begin
				if (scl_fall)
				begin
					s_d.bits = s_q.bits + 4'h1;
					if (s_q.bits == 4'h7)
					begin
						s_d.oe = 1'b0;
						s_d.st = I2C_ACKR;
					end
					else
					begin
						s_d.sh = {s_q.sh[6:0], 1'b0};
						s_d.oe = !s_q.sh[6];
					end
				end
			end
			I2C_ACKR:
			begin
				if (scl_rise)
					s_d.nack = sda_in;
				else if (scl_fall)
				begin
					s_d.st = I2C_IDLE;
					if (!s_q.nack)
					begin
						rd_load  = 1'b1;
						s_d.sh   = rd_val;
						s_d.oe   = !rd_val[7];
						s_d.ptr  = s_q.ptr + 8'h01;
						s_d.bits = 4'h0;
						s_d.st   = I2C_RD;
					end
				end
			end
			default: s_d.st = I2C_IDLE;
		endcase
		if (bus_start)
		begin
			s_d.st   = I2C_ADDR;
			s_d.bits = 4'h0;
			s_d.oe   = 1'b0;
		end
		else if (bus_stop)
		begin
			s_d.st = I2C_IDLE;
			s_d.oe = 1'b0;
		end
		// held in reset mode the mode register keeps its initial value
		if (!s_q.blk_run)
			s_d.cfg = MODE_RESET;
		if (sys_rst_in)
		begin
			s_d      = '0;
			s_d.st   = I2C_IDLE;
			s_d.scl  = 1'b1;
			s_d.sda  = 1'b1;
			s_d.cfg  = MODE_RESET;
		end
	end

	always_ff @(posedge clock_in)
		s_q <= s_d;

	assign meas.run_en = s_q.pwr && s_q.blk_run;
	assign meas.mode   = s_q.cfg.mode;
	assign meas.avg    = s_q.cfg.avg;
	assign sda_out     = s_q.lvl;
	assign sda_oe_out  = s_q.oe;

	chk_gate_write: assert property (
		@(posedge clock_in) disable iff (sys_rst_in)
		(wr_strobe && s_q.ptr == ADDR_MODE && !s_q.pwr && s_q.blk_run) |=> $stable(s_q.cfg))
		else $error("gated mode write was not dropped");
	chk_gate_read: assert property (
		@(posedge clock_in) disable iff (sys_rst_in)
		(rd_load && s_q.ptr >= GATED_LO && s_q.ptr <= GATED_HI && !gate_ok)
		|=> s_q.sh == GATED_READ)
		else $error("gated read did not return filler");
	chk_open_read: assert property (
		@(posedge clock_in) disable iff (sys_rst_in)
		(rd_load && s_q.ptr == ADDR_MODE && gate_ok) |=> s_q.sh == $past(s_q.cfg))
		else $error("open mode register read wrong");
	chk_pwr_reset: assert property (
		@(posedge clock_in) sys_rst_in |=> !s_q.pwr && !s_q.blk_run && !meas.run_en)
		else $error("power gate not cleared by reset");
	chk_hold_init: assert property (
		@(posedge clock_in) disable iff (sys_rst_in)
		!s_q.blk_run |=> s_q.cfg == MODE_RESET ##1 !meas.ready)
		else $error("mode register not initialised in reset mode");
	chk_frac_place: assert property (
		@(posedge clock_in) disable iff (sys_rst_in)
		gate_ok |-> frac_chk == {meas.press[5:0], 2'h0})
		else $error("fraction byte misplaced");
	chk_status_bit: assert property (
		@(posedge clock_in) disable iff (sys_rst_in)
		gate_ok |-> stat_chk == {7'h00, meas.ready})
		else $error("status byte does not show ready");
	chk_oneshot_back: assert property (
		@(posedge clock_in) disable iff (sys_rst_in)
		(meas.done && s_q.cfg.mode == MM_ONESHOT && !wr_strobe && s_q.blk_run)
		|=> s_q.cfg.mode == MM_STANDBY)
		else $error("one-shot did not return to standby");

endmodule : psrb_top

// *** verif/psrb_host.sv ***
/*
 psrb_host: two-wire bus master model that reaches the register bank.
 assumes the testbench resolves sda with a pull-up and clock_in is 50 MHz.
*/
module psrb_host #(
	parameter logic [6:0] DEV_ADDR = 7'h5d
) (
	// clock
	input  wire logic clock_in,
	// bus
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_oe_out
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] rb [5];
	int         nak_cnt;

	initial
	begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
		nak_cnt = 0;
	end

	// quarter bit of four clocks keeps every bus edge well apart
	task automatic q(input int n);
		repeat (4 * n) @(negedge clock_in);
	endtask : q

	task automatic bit_io(input logic b, output logic r);
		sda_oe_out = ~b;
		q(1);
		scl_out = 1'b1;
		q(1);
		r = sda_in;
		q(1);
		scl_out = 1'b0;
		q(1);
	endtask : bit_io

	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r);
		logic a;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(d[i], r[i]);
		end
		bit_io(last, a);
		if (d != 8'hff && a)
			nak_cnt++;
	endtask : xfer

	// also serves as repeated start
	task automatic start;
		sda_oe_out = 1'b0;
		q(1);
		scl_out = 1'b1;
		q(1);
		sda_oe_out = 1'b1;
		q(1);
		scl_out = 1'b0;
		q(1);
	endtask : start

	task automatic stop;
		sda_oe_out = 1'b1;
		q(1);
		scl_out = 1'b1;
		q(1);
		sda_oe_out = 1'b0;
		q(2);
	endtask : stop

	// only mapped addresses, reserved bit 2 zero
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, r);
		xfer(a, 1'b1, r);
		xfer(d, 1'b1, r);
		stop();
	endtask : wr

	task automatic rd(input logic [7:0] a, input int n);
		logic [7:0] r;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, r);
		xfer(a, 1'b1, r);
		start();
		xfer({DEV_ADDR, 1'b1}, 1'b1, r);
		for (int i = 0; i < n; i++)
		begin
			xfer(8'hff, i == n - 1, rb[i]);
		end
		stop();
	endtask : rd

endmodule : psrb_host

// *** verif/testbench.sv ***
/*
 testbench: self-checking bench of the pressure sensor register bank.
 assumes psrb_top with a shortened millisecond count and psrb_host as bus master.
*/
`define CHK(g, e) \
	begin \
		n_compared++; \
		if ((g) !== (e)) \
		begin \
			errors++; \
			$display("BAD %0t got %h exp %h", $time, g, e); \
		end \
	end

module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	// 200 cycles per ms keeps one-shot and cycle times apart from bus traffic
	localparam int         MSC       = 200;
	localparam logic [7:0] ID_FIRST  = 8'ha5; // arbitrary
	localparam logic [7:0] ID_SECOND = 8'h5a; // arbitrary

	logic        clock_in;
	logic        sys_rst_in;
	logic        scl;
	logic        sda;
	logic        d_out;
	logic        d_oe;
	logic        h_oe;
	logic [21:0] press;
	logic [15:0] temp;
	int          errors;
	int          n_compared;

	assign sda = !(h_oe || (d_oe && !d_out));

	psrb_top #(.MS_CYCLES(MSC), .IDENT_FIRST(ID_FIRST), .IDENT_SECOND(ID_SECOND)) psrb_top_i (
		.clock_in(clock_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda),
		.sda_out(d_out), .sda_oe_out(d_oe), .sensor_press_in(press), .sensor_temp_in(temp));

	psrb_host psrb_host_i (.clock_in(clock_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(h_oe));

	task automatic w(input int n);
		repeat (n) @(negedge clock_in);
	endtask : w

	task automatic rd1(input logic [7:0] a, input logic [7:0] e);
		psrb_host_i.rd(a, 1);
		`CHK(psrb_host_i.rb[0], e)
	endtask : rd1

	task automatic chk_res(input logic [21:0] p, input logic [15:0] t);
		psrb_host_i.rd(8'h1a, 5);
		`CHK(psrb_host_i.rb[0], p[21:14])
		`CHK(psrb_host_i.rb[1], p[13:6])
		`CHK(psrb_host_i.rb[2], {p[5:0], 2'b00})
		`CHK(psrb_host_i.rb[3], t[15:8])
		`CHK(psrb_host_i.rb[4], t[7:0])
	endtask : chk_res

	task automatic t_reset;
		rd1(8'h12, 8'h00);
		rd1(8'h13, 8'h00);
		psrb_host_i.wr(8'h0f, 8'h00);
		rd1(8'h0f, ID_FIRST);
		rd1(8'h10, ID_SECOND);
		rd1(8'h11, 8'h00);
		$display("test reset done");
	endtask : t_reset

	task automatic t_gate;
		psrb_host_i.wr(8'h14, 8'h22);
		rd1(8'h14, 8'h00);
		psrb_host_i.wr(8'h12, 8'h01);
		rd1(8'h12, 8'h01);
		rd1(8'h14, 8'h00);
		psrb_host_i.wr(8'h13, 8'h01);
		rd1(8'h13, 8'h01);
		rd1(8'h14, 8'h08);
		$display("test gate done");
	endtask : t_gate

	task automatic t_oneshot(input logic [2:0] avg, input logic [21:0] p, input logic [15:0] t);
		press = p;
		temp = t;
		psrb_host_i.wr(8'h14, {avg, 5'b01001});
		rd1(8'h19, 8'h00);
		// status sampled between the 6 ms and 9 ms ends, so only single-sample is done
		w(300);
		rd1(8'h19, {7'h00, avg == 3'h0});
		w(200);
		rd1(8'h19, 8'h01);
		rd1(8'h14, {avg, 5'b01000});
		chk_res(p, t);
		$display("test one shot done");
	endtask : t_oneshot

	task automatic t_cont;
		press = 22'h0f0f0f;
		temp = 16'h1357;
		psrb_host_i.wr(8'h14, 8'h0a);
		w(1300);
		rd1(8'h19, 8'h01);
		chk_res(22'h0f0f0f, 16'h1357);
		press = 22'h30c3c3;
		temp = 16'h9bdf;
		w(12000);
		chk_res(22'h30c3c3, 16'h9bdf);
		rd1(8'h14, 8'h0a);
		psrb_host_i.wr(8'h14, 8'h08);
		press = 22'h111111;
		w(12500);
		chk_res(22'h30c3c3, 16'h9bdf);
		$display("test continuous done");
	endtask : t_cont

	task automatic t_pdown;
		psrb_host_i.wr(8'h12, 8'h00);
		psrb_host_i.wr(8'h14, 8'h4a);
		rd1(8'h14, 8'h00);
		rd1(8'h19, 8'h00);
		psrb_host_i.wr(8'h12, 8'h01);
		rd1(8'h14, 8'h08);
		`CHK(psrb_host_i.nak_cnt, 0)
		$display("test power down done");
	endtask : t_pdown

	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	initial
	begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end

	// hang guard
	initial
	begin
		repeat (95000) @(posedge clock_in);
		errors++;
		end_sim();
	end

	initial
	begin
		errors = 0;
		n_compared = 0;
		sys_rst_in = 1'b1;
		press = 22'h0;
		temp = 16'h0;
		w(6);
		sys_rst_in = 1'b0;
		w(2);
		t_reset();
		t_gate();
		t_oneshot(3'h0, 22'h2abcde, 16'h4321);
		t_oneshot(3'h1, 22'h15a5a7, 16'hbeef);
		t_cont();
		t_pdown();
		end_sim();
	end

endmodule : testbench
